// *** srs_return_ctrl.sv ***
// program counter stack and subroutine return sequencing
//
// What this block does
// [RQ1] a return pops the newest address, adds one and loads the counter.
// [RQ2] a return on an empty stack raises the internal reset instead.
// [RQ3] an interrupt takes one level like a call and pairs with the
//       interrupt return.
// [RQ4] the stack holds thirty nested return addresses.
// [RQ5] four conditional returns act on zero set, zero clear, carry set
//       or carry clear.
// [RQ6] a failed condition leaves the stack alone and steps the counter.
// [RQ7] load-and-return is one 18-bit word taking two clock cycles.
// [RQ8] load-and-return writes its constant to the register while popping.
// [RQ9] the indirect call target is the low nibble of the first register
//       above all eight bits of the second, registers untouched.
// [RQ10] a call pushes its own address before jumping.
// [RQ11] a push onto a full stack raises the internal reset.
// [RQ12] plain and conditional returns change no flag and no register.
`timescale 1ns/1ps
module srs_return_ctrl #(
  parameter int unsigned DEPTH = srs_pkg::STACK_DEPTH
) (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  // decoded instruction, held for both cycles
  input  wire logic                        op_valid,
  input  wire srs_pkg::srs_op_t            op_code,
  input  wire logic [srs_pkg::ADDR_W-1:0]  call_target,
  input  wire logic [srs_pkg::DATA_W-1:0]  load_const,
  input  wire logic [srs_pkg::REG_SEL_W-1:0] load_reg_sel,
  // register file and flags
  input  wire logic [srs_pkg::DATA_W-1:0]  first_operand_register,
  input  wire logic [srs_pkg::DATA_W-1:0]  second_operand_register,
  input  wire logic                        zero_flag,
  input  wire logic                        carry_flag,
  // results
  output logic [srs_pkg::ADDR_W-1:0]       program_counter,
  output logic                             op_done,
  output logic                             reg_wr_en,
  output logic [srs_pkg::REG_SEL_W-1:0]    reg_wr_sel,
  output logic [srs_pkg::DATA_W-1:0]       reg_wr_data,
  output logic                             flags_wr_en,
  output logic                             interrupt_return,
  output logic                             internal_reset,
  output logic [srs_pkg::PTR_W-1:0]        stack_level
);
  localparam int unsigned AW = srs_pkg::ADDR_W;
  localparam int unsigned PW = srs_pkg::PTR_W;
  localparam logic [PW-1:0] FULL_LEVEL = PW'(DEPTH);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_pop(input srs_pkg::srs_op_t op);
    is_pop = op inside {srs_pkg::SRS_OP_RET, srs_pkg::SRS_OP_RET_Z,
                        srs_pkg::SRS_OP_RET_NZ, srs_pkg::SRS_OP_RET_C,
                        srs_pkg::SRS_OP_RET_NC, srs_pkg::SRS_OP_LOAD_RET,
                        srs_pkg::SRS_OP_INT_RET};
  endfunction : is_pop

  function automatic logic is_push(input srs_pkg::srs_op_t op);
    is_push = op inside {srs_pkg::SRS_OP_CALL, srs_pkg::SRS_OP_CALL_IND,
                         srs_pkg::SRS_OP_INTERRUPT};
  endfunction : is_push

  function automatic logic cond_met(input srs_pkg::srs_op_t op,
                                    input logic z, input logic c);
    unique case (op)
      srs_pkg::SRS_OP_RET_Z:  cond_met = z;   // see [RQ5]
      srs_pkg::SRS_OP_RET_NZ: cond_met = !z;  // see [RQ5]
      srs_pkg::SRS_OP_RET_C:  cond_met = c;   // see [RQ5]
      srs_pkg::SRS_OP_RET_NC: cond_met = !c;  // see [RQ5]
      default:                cond_met = 1'b1;
    endcase
  endfunction : cond_met

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  srs_pkg::srs_state_t state_q, state_d;
  logic [AW-1:0] pc_q, pc_d;
  logic [PW-1:0] lvl_q, lvl_d;
  logic          rst_q, rst_d;
  logic          done_q, done_d;
  logic          rwe_q, rwe_d;
  logic [srs_pkg::REG_SEL_W-1:0] rsel_q, rsel_d;
  logic [srs_pkg::DATA_W-1:0]    rdat_q, rdat_d;
  logic          iret_q, iret_d;
  logic          push_en;
  logic [PW-1:0] rd_addr;
  logic [AW-1:0] top_q;
  logic [AW-1:0] ind_target;
  logic          take;

  assign ind_target = {first_operand_register[srs_pkg::NIB_W-1:0],
                       second_operand_register};  // see [RQ9]
  assign take = cond_met(op_code, zero_flag, carry_flag);
  assign rd_addr = (lvl_q == srs_pkg::PTR_ZERO) ? srs_pkg::PTR_ZERO
                                                : lvl_q - srs_pkg::PTR_ONE;
  assign push_en = op_valid && (state_q == srs_pkg::SRS_ST_DECODE) &&
                   is_push(op_code) && (lvl_q != FULL_LEVEL);

  srs_stack_mem #(
    .DEPTH (DEPTH),
    .WIDTH (AW),
    .PTR_W (PW)
  ) u_mem (
    .clock     (clock),
    .arst_n    (arst_n),
    .wr_en     (push_en),
    .wr_addr   (lvl_q),
    .wr_data   (pc_q),        // see [RQ10]
    .rd_addr   (rd_addr),
    .rd_data_q (top_q)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    pc_d    = pc_q;
    lvl_d   = lvl_q;
    rst_d   = 1'b0;
    done_d  = 1'b0;
    rwe_d   = 1'b0;
    rsel_d  = rsel_q;
    rdat_d  = rdat_q;
    iret_d  = 1'b0;
    unique case (state_q)
      srs_pkg::SRS_ST_DECODE: begin
        if (op_valid && op_code != srs_pkg::SRS_OP_NONE) begin
          state_d = srs_pkg::SRS_ST_EXECUTE;
        end
      end
      srs_pkg::SRS_ST_EXECUTE: begin
        state_d = srs_pkg::SRS_ST_DECODE;
        done_d  = 1'b1;
        if (is_push(op_code)) begin
          if (lvl_q == FULL_LEVEL) begin
            rst_d = 1'b1;                          // see [RQ11]
          end else begin
            lvl_d = lvl_q + srs_pkg::PTR_ONE;      // see [RQ3] [RQ4]
            pc_d  = (op_code == srs_pkg::SRS_OP_CALL_IND) ? ind_target
                                                          : call_target;
          end
        end else if (is_pop(op_code)) begin
          if (!take) begin
            pc_d = pc_q + srs_pkg::PC_ONE;         // see [RQ6]
          end else if (lvl_q == srs_pkg::PTR_ZERO) begin
            rst_d = 1'b1;                          // see [RQ2]
          end else begin
            lvl_d  = lvl_q - srs_pkg::PTR_ONE;
            pc_d   = top_q + srs_pkg::PC_ONE;      // see [RQ1]
            iret_d = (op_code == srs_pkg::SRS_OP_INT_RET);  // see [RQ3]
            if (op_code == srs_pkg::SRS_OP_LOAD_RET) begin
              rwe_d  = 1'b1;                       // see [RQ7] [RQ8]
              rsel_d = load_reg_sel;
              rdat_d = load_const;
            end
          end
        end else begin
          pc_d = pc_q + srs_pkg::PC_ONE;
        end
        if (rst_d) begin
          pc_d  = srs_pkg::PC_RESET;
          lvl_d = srs_pkg::PTR_ZERO;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= srs_pkg::SRS_ST_DECODE;
      pc_q    <= srs_pkg::PC_RESET;
      lvl_q   <= srs_pkg::PTR_ZERO;
      rst_q   <= 1'b0;
      done_q  <= 1'b0;
      rwe_q   <= 1'b0;
      rsel_q  <= '0;
      rdat_q  <= '0;
      iret_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q    <= pc_d;
      lvl_q   <= lvl_d;
      rst_q   <= rst_d;
      done_q  <= done_d;
      rwe_q   <= rwe_d;
      rsel_q  <= rsel_d;
      rdat_q  <= rdat_d;
      iret_q  <= iret_d;
    end
  end

  assign program_counter  = pc_q;
  assign op_done          = done_q;
  assign reg_wr_en        = rwe_q;     // see [RQ12]
  assign reg_wr_sel       = rsel_q;
  assign reg_wr_data      = rdat_q;
  assign flags_wr_en      = 1'b0;      // see [RQ12]
  assign interrupt_return = iret_q;
  assign internal_reset   = rst_q;
  assign stack_level      = lvl_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ret_pc_inc_a: assert property (@(posedge clock) disable iff (!arst_n)
    state_q == srs_pkg::SRS_ST_EXECUTE && op_code == srs_pkg::SRS_OP_RET
    && lvl_q != srs_pkg::PTR_ZERO |=> pc_q == $past(top_q) + srs_pkg::PC_ONE)
    else $error("return pc wrong"); // see [RQ1]
  underflow_rst_a: assert property (@(posedge clock) disable iff (!arst_n)
    state_q == srs_pkg::SRS_ST_EXECUTE && is_pop(op_code) && take
    && lvl_q == srs_pkg::PTR_ZERO |=> rst_q && pc_q == srs_pkg::PC_RESET)
    else $error("underflow not reset"); // see [RQ2]
  int_level_a: assert property (@(posedge clock) disable iff (!arst_n)
    state_q == srs_pkg::SRS_ST_EXECUTE && op_code == srs_pkg::SRS_OP_INTERRUPT
    && lvl_q != FULL_LEVEL |=> lvl_q == $past(lvl_q) + srs_pkg::PTR_ONE)
    else $error("interrupt level wrong"); // see [RQ3]
  depth_cap_a: assert property (@(posedge clock) disable iff (!arst_n)
    lvl_q <= FULL_LEVEL) else $error("level past depth"); // see [RQ4]
  cond_skip_a: assert property (@(posedge clock) disable iff (!arst_n)
    state_q == srs_pkg::SRS_ST_EXECUTE && is_pop(op_code) && !take
    |=> $stable(lvl_q) && pc_q == $past(pc_q) + srs_pkg::PC_ONE)
    else $error("skip wrong"); // see [RQ5] [RQ6]
  load_two_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(rwe_q) |-> $past(state_q, 2) == srs_pkg::SRS_ST_DECODE
    && done_q) else $error("load timing wrong"); // see [RQ7] [RQ8]
  ind_target_a: assert property (@(posedge clock) disable iff (!arst_n)
    state_q == srs_pkg::SRS_ST_EXECUTE && op_code == srs_pkg::SRS_OP_CALL_IND
    && lvl_q != FULL_LEVEL |=> pc_q == $past(ind_target))
    else $error("indirect target wrong"); // see [RQ9]
  overflow_rst_a: assert property (@(posedge clock) disable iff (!arst_n)
    state_q == srs_pkg::SRS_ST_EXECUTE && is_push(op_code)
    && lvl_q == FULL_LEVEL |=> rst_q && lvl_q == srs_pkg::PTR_ZERO)
    else $error("overflow not reset"); // see [RQ11]
  no_reg_wr_a: assert property (@(posedge clock) disable iff (!arst_n)
    rwe_q |-> $past(op_code) == srs_pkg::SRS_OP_LOAD_RET)
    else $error("stray register write"); // see [RQ12]
endmodule : srs_return_ctrl

// *** srs_pkg.sv ***
// shared constants for the subroutine return stack control
package srs_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned STACK_DEPTH = 30;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned REG_SEL_W   = 4;
  localparam int unsigned PTR_W       = 5;
  localparam int unsigned NIB_W       = 4;
  localparam logic [PTR_W-1:0]  PTR_ZERO = 5'h00;
  localparam logic [PTR_W-1:0]  PTR_ONE  = 5'h01;
  localparam logic [ADDR_W-1:0] PC_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] PC_ONE   = 12'h001;

  // ---------------------------------------------------------------
  // operations seen by the sequencer
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SRS_OP_NONE      = 4'h0,
    SRS_OP_CALL      = 4'h1,
    SRS_OP_CALL_IND  = 4'h2,
    SRS_OP_RET       = 4'h3,
    SRS_OP_RET_Z     = 4'h4,
    SRS_OP_RET_NZ    = 4'h5,
    SRS_OP_RET_C     = 4'h6,
    SRS_OP_RET_NC    = 4'h7,
    SRS_OP_LOAD_RET  = 4'h8,
    SRS_OP_INT_RET   = 4'h9,
    SRS_OP_INTERRUPT = 4'ha
  } srs_op_t;

  // two cycle execution phases
  typedef enum logic [0:0] {
    SRS_ST_DECODE  = 1'b0,
    SRS_ST_EXECUTE = 1'b1
  } srs_state_t;
endpackage : srs_pkg

// *** srs_stack_mem.sv ***
// return address storage memory with registered read data
`timescale 1ns/1ps
module srs_stack_mem #(
  parameter int unsigned DEPTH  = srs_pkg::STACK_DEPTH,
  parameter int unsigned WIDTH  = srs_pkg::ADDR_W,
  parameter int unsigned PTR_W  = srs_pkg::PTR_W
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // write port
  input  wire logic             wr_en,
  input  wire logic [PTR_W-1:0] wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read port
  input  wire logic [PTR_W-1:0] rd_addr,
  output logic      [WIDTH-1:0] rd_data_q
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule : srs_stack_mem

// *** srs_prog_mem.sv ***
// program memory model supplying call targets and load constants
`timescale 1ns/1ps
module srs_prog_mem (
  // fetch address
  input  wire logic [srs_pkg::ADDR_W-1:0] fetch_addr,
  // instruction fields
  output logic      [srs_pkg::ADDR_W-1:0] target,
  output logic      [srs_pkg::DATA_W-1:0] konst
);
  logic [19:0] rom [0:4095];

  // ---------------------------------------------------------------
  // fixed contents, read without delay
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4096; i++) begin
      rom[i] = {8'h96 ^ i[7:0], 12'ha5c ^ i[11:0]};
    end
  end
  assign target = rom[fetch_addr][11:0];
  assign konst  = rom[fetch_addr][19:12];
endmodule : srs_prog_mem

// *** tb_subroutine_return_stack_control.sv ***
// self-checking bench for the return stack control
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected at %0t: got %h want %h", \
  $time, (g), (e)); end end
module tb_subroutine_return_stack_control;
  logic             clock = 1'b0;
  logic             arst_n = 1'b0;
  logic             op_valid = 1'b0;
  srs_pkg::srs_op_t op_code = srs_pkg::SRS_OP_NONE;
  logic [3:0]       load_reg_sel = 4'h0;
  logic [7:0]       first_op = 8'h00;
  logic [7:0]       second_op = 8'h00;
  logic             zero_flag = 1'b0;
  logic             carry_flag = 1'b0;
  logic [11:0]      call_target, program_counter, pc_m = 12'h000;
  logic [7:0]       load_const, reg_wr_data;
  logic [3:0]       reg_wr_sel;
  logic [4:0]       stack_level;
  logic             op_done, reg_wr_en, flags_wr_en;
  logic             interrupt_return, internal_reset;
  logic [32:0]      exp_q [$];
  logic [32:0]      got_v, want_v;
  logic [11:0]      stk [$];
  int               err_count = 0;
  int               n_checks = 0;
  srs_pkg::srs_op_t conds [4] = '{srs_pkg::SRS_OP_RET_Z,
    srs_pkg::SRS_OP_RET_NZ, srs_pkg::SRS_OP_RET_C, srs_pkg::SRS_OP_RET_NC};

  always #25 clock = ~clock;

  srs_prog_mem srs_prog_mem_inst (.fetch_addr(program_counter),
    .target(call_target), .konst(load_const));

  srs_return_ctrl srs_return_ctrl_inst (.clock(clock), .arst_n(arst_n),
    .op_valid(op_valid), .op_code(op_code), .call_target(call_target),
    .load_const(load_const), .load_reg_sel(load_reg_sel),
    .first_operand_register(first_op), .second_operand_register(second_op),
    .zero_flag(zero_flag), .carry_flag(carry_flag),
    .program_counter(program_counter), .op_done(op_done),
    .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel),
    .reg_wr_data(reg_wr_data), .flags_wr_en(flags_wr_en),
    .interrupt_return(interrupt_return), .internal_reset(internal_reset),
    .stack_level(stack_level));

  // ---------------------------------------------------------------
  // closing report
  // ---------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // driver: present one op, note its result, wait for completion
  // ---------------------------------------------------------------
  task do_op(input srs_pkg::srs_op_t op);
    logic ld, ir, rst, pop, cnd;
    int   n;
    op_valid = 1'b1;
    op_code = op;
    load_reg_sel = 4'($urandom);
    first_op = 8'($urandom);
    second_op = 8'($urandom);
    {ld, ir, rst, pop, cnd} = 5'h00;
    case (op)
      srs_pkg::SRS_OP_CALL, srs_pkg::SRS_OP_INTERRUPT,
      srs_pkg::SRS_OP_CALL_IND: begin
        if (stk.size() == 30) begin
          rst = 1'b1;
        end else begin
          stk.push_back(pc_m);
          pc_m = (op == srs_pkg::SRS_OP_CALL_IND) ?
                 {first_op[3:0], second_op} : call_target;
        end
      end
      srs_pkg::SRS_OP_RET_Z:    {cnd, pop} = {1'b1, zero_flag};
      srs_pkg::SRS_OP_RET_NZ:   {cnd, pop} = {1'b1, ~zero_flag};
      srs_pkg::SRS_OP_RET_C:    {cnd, pop} = {1'b1, carry_flag};
      srs_pkg::SRS_OP_RET_NC:   {cnd, pop} = {1'b1, ~carry_flag};
      srs_pkg::SRS_OP_LOAD_RET: {ld, pop} = 2'b11;
      srs_pkg::SRS_OP_INT_RET:  {ir, pop} = 2'b11;
      default:                  pop = 1'b1;
    endcase
    if (cnd && !pop) begin
      pc_m = pc_m + 12'h001;
    end else if (pop && stk.size() == 0) begin
      rst = 1'b1;
    end else if (pop) begin
      pc_m = stk.pop_back() + 12'h001;
    end
    if (rst) begin
      stk.delete();
      pc_m = 12'h000;
      {ld, ir} = 2'b00;
    end
    exp_q.push_back({pc_m, 5'(stk.size()), ld, ir, rst, 1'b0,
                     ld ? {load_reg_sel, load_const} : 12'h000});
    n = 0;
    do begin
      @(posedge clock);
      #5;
      n++;
    end while (op_done !== 1'b1 && n < 8);
    `CHK(n, 2)
    if (n >= 8) begin
      report_and_stop();
    end
  endtask : do_op

  // ---------------------------------------------------------------
  // monitor: compare every completion with the oldest note
  // ---------------------------------------------------------------
  always @(negedge clock) begin
    if (op_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("unexpected at %0t: completion without request", $time);
      end else begin
        got_v = {program_counter, stack_level, reg_wr_en,
                 interrupt_return, internal_reset, flags_wr_en,
                 reg_wr_en ? {reg_wr_sel, reg_wr_data} : 12'h000};
        want_v = exp_q.pop_front();
        `CHK(got_v, want_v)
      end
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(26));
    repeat (8) @(posedge clock);
    #5 arst_n = 1'b1;
    @(posedge clock);
    #5;
    do_op(srs_pkg::SRS_OP_RET);
    do_op(srs_pkg::SRS_OP_CALL);
    do_op(srs_pkg::SRS_OP_CALL_IND);
    do_op(srs_pkg::SRS_OP_RET);
    do_op(srs_pkg::SRS_OP_RET);
    for (int k = 0; k < 8; k++) begin
      do_op(srs_pkg::SRS_OP_CALL);
      zero_flag = k[0];
      carry_flag = k[0];
      do_op(conds[k / 2]);
    end
    repeat (4) begin
      do_op(srs_pkg::SRS_OP_CALL_IND);
      do_op(srs_pkg::SRS_OP_LOAD_RET);
    end
    do_op(srs_pkg::SRS_OP_INTERRUPT);
    do_op(srs_pkg::SRS_OP_INT_RET);
    while (stk.size() > 0) begin
      do_op(srs_pkg::SRS_OP_RET);
    end
    repeat (30) do_op(srs_pkg::SRS_OP_CALL);
    repeat (30) do_op(srs_pkg::SRS_OP_RET);
    repeat (31) do_op(srs_pkg::SRS_OP_CALL);
    op_valid = 1'b0;
    op_code = srs_pkg::SRS_OP_NONE;
    repeat (4) @(posedge clock);
    `CHK(exp_q.size(), 0)
    report_and_stop();
  end
endmodule : tb_subroutine_return_stack_control
